// *** src/ctmp_dev_end.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ctmp_params.svh"

// Operation
// - Plain write: address, way, data, write select
// - Plain write repeats no faster than 8 clocks
// - Stepping write: previous write address plus one
// - Write address overflow wraps to zero, toggles way
// - Stepping write reuses previous write data word
// - Stepping write must follow some write
// - Stepping write: increment and write selects, array
// - Stepping writes may repeat every clock
// - Plain read: address, way, array, selects low
// - Read data and strobe 15 clocks after command
// - Bus released the interface cycle after response
// - Plain read repeats no faster than 17 clocks
// - Stepping read repeats no faster than 17 clocks
// - Stepping read: previous access address plus one
// - Read address overflow wraps to zero, toggles way
// - Stepping read: increment high, write select low
// - Unused bits written zero, read undefined
// - Wait 100 ms after mode entry
// - Only bus, strobe and mode bit matter
module ctmp_dev_end #(
  parameter int DIV = `CTMP_IFC_DIV
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  ctmp_if.dev_mp    link,
  output logic      mode_active,
  output logic      resp_driving
);
  import ctmp_pkg::*;

  localparam int         WORDS    = 2 ** (`CTMP_ADDR_W + 1);
  localparam logic [4:0] NRM_HOLD = 5'(`CTMP_NRM_WR_RPT - 1);
  localparam logic [4:0] INC_HOLD = 5'(`CTMP_INC_WR_RPT - 1);
  localparam logic [4:0] RD_HOLD  = 5'(`CTMP_RD_RPT - 1);
  localparam logic [4:0] LAT_LOAD = 5'(`CTMP_RD_LAT - 1);
  localparam logic [4:0] GUARD    = 5'(`CTMP_ECHO_GUARD);
  localparam ctmp_arr_t  N_ARR    = 3'(`CTMP_N_ARRAYS);

  localparam ctmp_dev_s_t RST = '{
    st       : dev_idle,
    s1_val_n : 1'b1,
    s2_val_n : 1'b1,
    val_n    : 1'b1,
    default  : '0
  };

  ctmp_dev_s_t q, d;
  ctmp_data_t  mem [`CTMP_N_ARRAYS][WORDS];

  logic        tick;
  logic        cmd_inc;
  logic        cmd_wr;
  ctmp_arr_t   cmd_arr;
  ctmp_addr_t  cmd_addr;
  logic        cmd_way;
  ctmp_addr_t  step_addr;
  logic        step_carry;
  ctmp_addr_t  tgt_addr;
  logic        tgt_way;
  logic        accept;
  logic        mem_we;
  ctmp_data_t  rd_word;

  ctmp_tick_div #(
    .DIV (DIV)
  ) u_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (tick)
  );

  // Field decode of the synchronised command word
  always_comb begin
    cmd_inc  = q.s2_bus[`CTMP_INC_BIT];
    cmd_wr   = q.s2_bus[`CTMP_WR_BIT];
    cmd_arr  = q.s2_bus[`CTMP_ARR_LO +: `CTMP_ARR_W];
    cmd_addr = q.s2_bus[`CTMP_ADDR_LO +: `CTMP_ADDR_W];
    cmd_way  = q.s2_bus[`CTMP_WAY_BIT];
  end

  // Writes step from the last write, reads from the last access of any kind
  always_comb begin
    if (cmd_wr) begin
      {step_carry, step_addr} = {1'b0, q.wr_addr} + 13'h0001;
    end else begin
      {step_carry, step_addr} = {1'b0, q.ac_addr} + 13'h0001;
    end
    if (cmd_inc) begin
      tgt_addr = step_addr;
      tgt_way  = (cmd_wr ? q.wr_way : q.ac_way) ^ step_carry;
    end else begin
      tgt_addr = cmd_addr;
      tgt_way  = cmd_way;
    end
  end

  // Arrays 5 to 7 do not exist: reads return zero, writes are dropped
  assign rd_word = (cmd_arr < N_ARR) ? mem[cmd_arr][{tgt_way, tgt_addr}] : '0;

  // Only the strobe, the bus and the mode bit are looked at
  assign accept = tick && (q.st == dev_idle) && !q.s2_val_n && q.s2_en && (q.hold == 5'h00);

  always_comb begin
    d      = q;
    mem_we = 1'b0;

    d.s1_bus   = link.sys_addr_data_bus;
    d.s2_bus   = q.s1_bus;
    d.s1_val_n = link.bus_valid_strobe_n;
    d.s2_val_n = q.s1_val_n;
    d.s1_en    = link.cache_test_enable_bit;
    d.s2_en    = q.s1_en;

    if (q.hold != 5'h00) begin
      d.hold = q.hold - 5'h01;
    end

    case (q.st)
      dev_idle: begin
        if (accept) begin
          d.ac_addr = tgt_addr;
          d.ac_way  = tgt_way;
          if (cmd_wr) begin
            mem_we    = 1'b1;
            d.wr_addr = tgt_addr;
            d.wr_way  = tgt_way;
            if (cmd_inc) begin
              d.wr_data = q.wr_data;
              d.hold    = INC_HOLD;
            end else begin
              d.wr_data = q.s2_bus[`CTMP_DATA_W-1:0];
              d.hold    = NRM_HOLD;
            end
          end else begin
            d.rd_data = rd_word;
            d.lat     = LAT_LOAD;
            d.hold    = RD_HOLD;
            d.st      = dev_lat;
          end
        end
      end
      dev_lat: begin
        if (q.lat != 5'h00) begin
          d.lat = q.lat - 5'h01;
        end else if (tick) begin
          // Upper bits are left at zero rather than undefined
          d.bus_out = {{(`CTMP_BUS_W - `CTMP_DATA_W){1'b0}}, q.rd_data};
          d.bus_oe  = 1'b1;
          d.val_n   = 1'b0;
          d.val_oe  = 1'b1;
          d.st      = dev_drive;
        end
      end
      dev_drive: begin
        if (tick) begin
          d.bus_oe = 1'b0;
          d.val_n  = 1'b1;
          d.val_oe = 1'b0;
          d.st     = dev_idle;
          // Own strobe still sits in the synchroniser; blank it out
          if (q.hold < GUARD) begin
            d.hold = GUARD;
          end
        end
      end
      default: begin
        d.st = dev_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  // Array contents are not reset, as in a real RAM
  always_ff @(posedge core_clk) begin
    if (mem_we && (cmd_arr < N_ARR)) begin
      mem[cmd_arr][{tgt_way, tgt_addr}] <= d.wr_data;
    end
  end

  assign link.dev_bus_out = q.bus_out;
  assign link.dev_bus_oe  = q.bus_oe;
  assign link.dev_val_n   = q.val_n;
  assign link.dev_val_oe  = q.val_oe;
  assign mode_active      = q.s2_en;
  assign resp_driving     = q.val_oe;
endmodule : ctmp_dev_end

`default_nettype wire

// *** src/ctmp_params.svh ***
`ifndef CTMP_PARAMS_SVH
`define CTMP_PARAMS_SVH

// Bus layout
`define CTMP_BUS_W       58
`define CTMP_DATA_W      40
`define CTMP_ADDR_W      12
`define CTMP_ADDR_LO     46
`define CTMP_WAY_BIT     45
`define CTMP_INC_BIT     44
`define CTMP_WR_BIT      43
`define CTMP_ARR_LO      40
`define CTMP_ARR_W       3
`define CTMP_N_ARRAYS    5

// Repeat rates and latency, in processor clocks
`define CTMP_NRM_WR_RPT  8
`define CTMP_INC_WR_RPT  1
`define CTMP_RD_RPT      17
`define CTMP_RD_LAT      15

// Settle time after mode entry
`define CTMP_CLK_KHZ     125000
`define CTMP_SETTLE_MS   100
`define CTMP_SETTLE_CYC  (`CTMP_SETTLE_MS * `CTMP_CLK_KHZ)

// Interface clock divisor and echo blanking
`define CTMP_IFC_DIV     2
`define CTMP_ECHO_GUARD  3

`endif

// *** src/ctmp_pkg.sv ***
`include "ctmp_params.svh"

package ctmp_pkg;

  typedef logic [`CTMP_BUS_W-1:0]  ctmp_bus_t;
  typedef logic [`CTMP_DATA_W-1:0] ctmp_data_t;
  typedef logic [`CTMP_ADDR_W-1:0] ctmp_addr_t;
  typedef logic [`CTMP_ARR_W-1:0]  ctmp_arr_t;

  // Bit 0 selects auto-increment, bit 1 selects read
  typedef enum logic [1:0] {
    plain_write_cmd    = 2'h0,
    stepping_write_cmd = 2'h1,
    plain_read_cmd     = 2'h2,
    stepping_read_cmd  = 2'h3
  } ctmp_kind_t;

  typedef enum logic [1:0] {dev_idle = 2'h0, dev_lat = 2'h1, dev_drive = 2'h3} ctmp_dev_st_t;
  typedef enum logic [1:0] {host_idle = 2'h0, host_drive = 2'h1, host_wait = 2'h3} ctmp_host_st_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } ctmp_div_s_t;

  typedef struct packed {
    ctmp_bus_t    s1_bus, s2_bus;
    logic         s1_val_n, s2_val_n, s1_en, s2_en;
    ctmp_dev_st_t st;
    logic [4:0]   lat, hold;
    ctmp_addr_t   wr_addr, ac_addr;
    logic         wr_way, ac_way;
    ctmp_data_t   wr_data, rd_data;
    ctmp_bus_t    bus_out;
    logic         bus_oe, val_n, val_oe;
  } ctmp_dev_s_t;

  typedef struct packed {
    ctmp_bus_t     s1_bus, s2_bus;
    logic          s1_val_n, s2_val_n;
    ctmp_host_st_t st;
    logic [7:0]    hold, guard;
    logic [23:0]   settle;
    logic          en;
    ctmp_bus_t     bus_out;
    logic          bus_oe, val_n, val_oe;
    logic          rd_pend, ready, taken, rsp_valid;
    ctmp_data_t    rsp_data;
  } ctmp_host_s_t;

endpackage : ctmp_pkg

// *** src/ctmp_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface ctmp_if;
  import ctmp_pkg::*;

  ctmp_bus_t sys_addr_data_bus;
  logic      bus_valid_strobe_n;
  logic      cache_test_enable_bit;
  ctmp_bus_t dev_bus_out;
  logic      dev_bus_oe;
  logic      dev_val_n;
  logic      dev_val_oe;
  ctmp_bus_t host_bus_out;
  logic      host_bus_oe;
  logic      host_val_n;
  logic      host_val_oe;

  // Undriven bus reads as zero, undriven strobe as idle high
  assign sys_addr_data_bus  = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : '0);
  assign bus_valid_strobe_n = dev_val_oe ? dev_val_n : (host_val_oe ? host_val_n : 1'b1);

  modport dev_mp (
    input  sys_addr_data_bus, bus_valid_strobe_n, cache_test_enable_bit,
    output dev_bus_out, dev_bus_oe, dev_val_n, dev_val_oe
  );

  modport host_mp (
    input  sys_addr_data_bus, bus_valid_strobe_n,
    output cache_test_enable_bit, host_bus_out, host_bus_oe, host_val_n, host_val_oe
  );
endinterface : ctmp_if

`default_nettype wire

// *** src/ctmp_tick_div.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ctmp_params.svh"

// Interface clock as a one-cycle enable, once every DIV processor clocks
module ctmp_tick_div #(
  parameter int DIV = `CTMP_IFC_DIV
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  output logic      tick
);
  import ctmp_pkg::*;

  localparam logic [7:0] LAST = 8'(DIV - 1);

  ctmp_div_s_t q, d;

  always_comb begin
    d = q;
    if (q.cnt == LAST) begin
      d.cnt  = 8'h00;
      d.tick = 1'b1;
    end else begin
      d.cnt  = q.cnt + 8'h01;
      d.tick = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule : ctmp_tick_div

`default_nettype wire

// *** src/ctmp_host_end.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ctmp_params.svh"

module ctmp_host_end #(
  parameter int          DIV        = `CTMP_IFC_DIV,
  parameter logic [23:0] SETTLE_CYC = 24'(`CTMP_SETTLE_CYC)
) (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  ctmp_if.host_mp                  link,
  input  wire logic                mode_req,
  input  wire logic                cmd_valid,
  input  wire ctmp_pkg::ctmp_kind_t cmd_kind,
  input  wire ctmp_pkg::ctmp_addr_t cmd_addr,
  input  wire logic                cmd_way,
  input  wire ctmp_pkg::ctmp_arr_t  cmd_array,
  input  wire ctmp_pkg::ctmp_data_t cmd_data,
  output logic                     cmd_ready,
  output logic                     cmd_taken,
  output logic                     rsp_valid,
  output ctmp_pkg::ctmp_data_t     rsp_data
);
  import ctmp_pkg::*;

  // Processor-clock intervals rounded up to whole interface cycles
  localparam logic [7:0] NRM_T = 8'((`CTMP_NRM_WR_RPT + DIV - 1) / DIV - 1);
  localparam logic [7:0] INC_T = 8'((`CTMP_INC_WR_RPT + DIV - 1) / DIV - 1);
  localparam logic [7:0] RD_T  = 8'((`CTMP_RD_RPT + DIV - 1) / DIV - 1);
  localparam logic [7:0] GUARD = 8'(DIV + `CTMP_ECHO_GUARD);

  localparam ctmp_host_s_t RST = '{
    st       : host_idle,
    s1_val_n : 1'b1,
    s2_val_n : 1'b1,
    val_n    : 1'b1,
    default  : '0
  };

  ctmp_host_s_t q, d;
  logic         tick;
  logic         accept;
  ctmp_bus_t    cw;

  ctmp_tick_div #(
    .DIV (DIV)
  ) u_div (
    .core_clk (core_clk),
    .rstn     (rstn),
    .tick     (tick)
  );

  // Unused fields go out as zero
  always_comb begin
    cw                                    = '0;
    cw[`CTMP_INC_BIT]                     = cmd_kind[0];
    cw[`CTMP_WR_BIT]                      = ~cmd_kind[1];
    cw[`CTMP_ARR_LO +: `CTMP_ARR_W]       = cmd_array;
    if (!cmd_kind[0]) begin
      cw[`CTMP_ADDR_LO +: `CTMP_ADDR_W]   = cmd_addr;
      cw[`CTMP_WAY_BIT]                   = cmd_way;
    end
    if (cmd_kind == plain_write_cmd) begin
      cw[`CTMP_DATA_W-1:0]                = cmd_data;
    end
  end

  assign accept = tick && cmd_valid && (q.st == host_idle) && (q.hold == 8'h00)
                  && (q.settle == 24'h000000) && q.en;

  always_comb begin
    d           = q;
    d.s1_bus    = link.sys_addr_data_bus;
    d.s2_bus    = q.s1_bus;
    d.s1_val_n  = link.bus_valid_strobe_n;
    d.s2_val_n  = q.s1_val_n;
    d.en        = mode_req;
    d.taken     = 1'b0;
    d.rsp_valid = 1'b0;

    if (mode_req && !q.en) begin
      d.settle = SETTLE_CYC;
    end else if (q.settle != 24'h000000) begin
      d.settle = q.settle - 24'h000001;
    end
    if (tick && (q.hold != 8'h00)) begin
      d.hold = q.hold - 8'h01;
    end
    if (q.guard != 8'h00) begin
      d.guard = q.guard - 8'h01;
    end

    case (q.st)
      host_idle: begin
        if (accept) begin
          d.bus_out = cw;
          d.bus_oe  = 1'b1;
          d.val_n   = 1'b0;
          d.val_oe  = 1'b1;
          d.rd_pend = cmd_kind[1];
          d.guard   = GUARD;
          d.taken   = 1'b1;
          d.st      = host_drive;
          case (cmd_kind)
            plain_write_cmd:    d.hold = NRM_T;
            stepping_write_cmd: d.hold = INC_T;
            default:            d.hold = RD_T;
          endcase
        end
      end
      host_drive: begin
        if (tick) begin
          d.bus_oe = 1'b0;
          d.val_n  = 1'b1;
          d.val_oe = 1'b0;
          d.st     = q.rd_pend ? host_wait : host_idle;
        end
      end
      host_wait: begin
        // A lost response stalls the agent here until reset
        if ((q.guard == 8'h00) && !q.s2_val_n) begin
          d.rsp_valid = 1'b1;
          d.rsp_data  = q.s2_bus[`CTMP_DATA_W-1:0];
          d.rd_pend   = 1'b0;
          d.st        = host_idle;
        end
      end
      default: begin
        d.st = host_idle;
      end
    endcase

    d.ready = (d.st == host_idle) && (d.hold == 8'h00) && (d.settle == 24'h000000) && d.en;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign link.cache_test_enable_bit = q.en;
  assign link.host_bus_out          = q.bus_out;
  assign link.host_bus_oe           = q.bus_oe;
  assign link.host_val_n            = q.val_n;
  assign link.host_val_oe           = q.val_oe;
  assign cmd_ready                  = q.ready;
  assign cmd_taken                  = q.taken;
  assign rsp_valid                  = q.rsp_valid;
  assign rsp_data                   = q.rsp_data;
endmodule : ctmp_host_end

`default_nettype wire

// *** verification/ctmp_checker.sv ***
`timescale 1ns/100ps
`default_nettype none

module ctmp_checker #(
  parameter int DIV    = 2,
  parameter int SETTLE = 20
) (
  input wire logic                core_clk,
  input wire logic                rstn,
  input wire ctmp_pkg::ctmp_bus_t sys_addr_data_bus,
  input wire logic                bus_valid_strobe_n,
  input wire logic                cache_test_enable_bit,
  input wire logic                dev_bus_oe,
  input wire logic                dev_val_n,
  input wire logic                dev_val_oe,
  input wire logic                host_bus_oe,
  input wire logic                host_val_n,
  input wire logic                host_val_oe
);
  import ctmp_pkg::*;

  logic [7:0] low_q;
  logic [7:0] en_q;
  logic [5:0] gap_q;
  logic [4:0] need_q;
  logic       cmd_start;

  // A strobe held low counts as a new command on every interface cycle; the host end raises it between back-to-back stepping writes
  assign cmd_start = host_val_oe && !host_val_n && ((low_q % DIV) == 0);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      low_q  <= 8'h00;
      en_q   <= 8'h00;
      gap_q  <= 6'h00;
      need_q <= 5'h00;
    end else begin
      low_q <= bus_valid_strobe_n ? 8'h00 : low_q + 8'h01;
      en_q  <= !cache_test_enable_bit ? 8'h00 : ((en_q == 8'hFF) ? en_q : en_q + 8'h01);
      if (cmd_start) begin
        gap_q  <= 6'h01;
        need_q <= !sys_addr_data_bus[43] ? 5'h11 : (sys_addr_data_bus[44] ? 5'h01 : 5'h08);
      end else if (gap_q != 6'h3F) begin
        gap_q <= gap_q + 6'h01;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_unused_zero: assert property (cmd_start |-> (sys_addr_data_bus[39:0] == '0 ||
    (sys_addr_data_bus[43] && !sys_addr_data_bus[44])) && (!sys_addr_data_bus[44] || sys_addr_data_bus[57:45] == '0))
    else $error("unused command bits not zero");
  a_strobe_width: assert property ($rose(bus_valid_strobe_n) |-> low_q != 0 && (low_q % DIV) == 0)
    else $error("strobe not whole interface cycles");
  a_rsp_latency: assert property ($rose(dev_val_oe) |-> need_q == 5'h11 && gap_q >= 15 && gap_q <= 24)
    else $error("read response outside latency window");
  a_rd_answer: assert property (cmd_start && !sys_addr_data_bus[43] |-> ##[15:24] $rose(dev_val_oe))
    else $error("read command got no response");
  a_rsp_release: assert property ($rose(dev_val_oe) |-> dev_bus_oe && !dev_val_n
    ##2 !dev_val_oe && !dev_bus_oe)
    else $error("response not released after one interface cycle");
  a_single_master: assert property (!(dev_bus_oe && host_bus_oe))
    else $error("both ends drive the bus");
  a_cmd_spacing: assert property (cmd_start |-> gap_q >= need_q)
    else $error("command issued before repeat interval");
  a_settle_wait: assert property (cmd_start |-> cache_test_enable_bit && en_q >= SETTLE)
    else $error("command issued before settle time");
endmodule : ctmp_checker

`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb;
  import ctmp_pkg::*;

  localparam int         DIV    = 2;
  localparam int         SETTLE = 20;
  localparam ctmp_data_t D0     = 40'h123456789A;
  localparam ctmp_data_t D1     = 40'hA55A0FF0C3;

  logic       core_clk;
  logic       rstn;
  logic       mode_req;
  logic       cmd_valid;
  ctmp_kind_t cmd_kind;
  ctmp_addr_t cmd_addr;
  logic       cmd_way;
  ctmp_arr_t  cmd_array;
  ctmp_data_t cmd_data;
  logic       cmd_taken;
  logic       rsp_valid;
  ctmp_data_t rsp_data;
  logic       mode_active;
  logic       cmd_ready;
  logic       resp_driving;
  int         error_cnt   = 0;
  int         comparisons = 0;
  int         cycles      = 0;

  ctmp_if bus_if ();

  ctmp_dev_end #(.DIV(DIV)) i_ctmp_dev_end (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .link         (bus_if.dev_mp),
    .mode_active  (mode_active),
    .resp_driving (resp_driving)
  );

  ctmp_host_end #(.DIV(DIV), .SETTLE_CYC(24'(SETTLE))) i_ctmp_host_end (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .link      (bus_if.host_mp),
    .mode_req  (mode_req),
    .cmd_valid (cmd_valid),
    .cmd_kind  (cmd_kind),
    .cmd_addr  (cmd_addr),
    .cmd_way   (cmd_way),
    .cmd_array (cmd_array),
    .cmd_data  (cmd_data),
    .cmd_ready (cmd_ready),
    .cmd_taken (cmd_taken),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data)
  );

  ctmp_checker #(.DIV(DIV), .SETTLE(SETTLE)) i_ctmp_checker (
    .core_clk              (core_clk),
    .rstn                  (rstn),
    .sys_addr_data_bus     (bus_if.sys_addr_data_bus),
    .bus_valid_strobe_n    (bus_if.bus_valid_strobe_n),
    .cache_test_enable_bit (bus_if.cache_test_enable_bit),
    .dev_bus_oe            (bus_if.dev_bus_oe),
    .dev_val_n             (bus_if.dev_val_n),
    .dev_val_oe            (bus_if.dev_val_oe),
    .host_bus_oe           (bus_if.host_bus_oe),
    .host_val_n            (bus_if.host_val_n),
    .host_val_oe           (bus_if.host_val_oe)
  );

  always #4 core_clk = ~core_clk;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // Whole run needs well under 3000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic check(input string name, input ctmp_data_t seen, input ctmp_data_t exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Junk in unused fields is on purpose: the host end must zero them on the bus
  task automatic send(input ctmp_kind_t k, input ctmp_addr_t a, input logic w, input ctmp_arr_t r,
                      input ctmp_data_t d);
    int n;
    cmd_kind  <= k;
    cmd_addr  <= a;
    cmd_way   <= w;
    cmd_array <= r;
    cmd_data  <= d;
    cmd_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmd_taken !== 1'b1 && n < 400);
    check("cmd_taken", {39'h0, cmd_taken}, 40'h0000000001);
    check("cmd_ready", {39'h0, cmd_ready}, 40'h0000000000);
    cmd_valid <= 1'b0;
    @(posedge core_clk);
  endtask : send

  task automatic rd(input ctmp_kind_t k, input ctmp_addr_t a, input logic w, input ctmp_arr_t r,
                    input ctmp_data_t exp);
    int   n;
    logic drv;
    send(k, a, w, r, D1);
    n   = 0;
    drv = 1'b0;
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
      // The device must have taken the bus at some point before the answer arrives
      if (resp_driving === 1'b1) begin
        drv = 1'b1;
      end
    end
    check("rsp_valid", {39'h0, rsp_valid}, 40'h0000000001);
    check("rsp_data", rsp_data, exp);
    check("resp_driving", {39'h0, drv}, 40'h0000000001);
  endtask : rd

  initial begin
    core_clk  = 1'b0;
    rstn      = 1'b0;
    mode_req  = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind  = plain_write_cmd;
    cmd_addr  = 12'h000;
    cmd_way   = 1'b0;
    cmd_array = 3'h0;
    cmd_data  = 40'h0000000000;
    repeat (10) @(posedge core_clk);
    rstn     <= 1'b1;
    mode_req <= 1'b1;
    @(posedge core_clk);
    send(plain_write_cmd, 12'h010, 1'b0, 3'h0, D0);
    send(stepping_write_cmd, 12'h555, 1'b1, 3'h0, D1);
    send(stepping_write_cmd, 12'h555, 1'b1, 3'h0, D1);
    rd(plain_read_cmd, 12'h011, 1'b0, 3'h0, D0);
    rd(stepping_read_cmd, 12'h555, 1'b1, 3'h0, D0);
    for (int r = 0; r < 5; r++) begin
      send(plain_write_cmd, 12'hFFF, 1'b0, 3'(r), D1 ^ 40'(r));
      send(stepping_write_cmd, 12'h000, 1'b0, 3'(r), D0);
      rd(plain_read_cmd, 12'hFFF, 1'b0, 3'(r), D1 ^ 40'(r));
      rd(stepping_read_cmd, 12'h000, 1'b0, 3'(r), D1 ^ 40'(r));
    end
    rd(plain_read_cmd, 12'h000, 1'b1, 3'h4, D1 ^ 40'h0000000004);
    rd(plain_read_cmd, 12'h010, 1'b0, 3'h5, 40'h0000000000);
    check("mode_active", {39'h0, mode_active}, 40'h0000000001);
    complete_run();
  end
endmodule : tb

`default_nettype wire
